// ==== hw/switch_fwd_pkg.sv ====
/*
  Constants for the switch forwarding and QoS block: register offsets,
  field positions, table sizes and reset values.
  Assumes a byte-addressed 32-bit register port with 8 address bits.
*/
package switch_fwd_pkg;
  // Register byte offsets.
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_PCFG = 8'h04;
  localparam logic [7:0] A_PMAP = 8'h08;
  localparam logic [7:0] A_DTAG0 = 8'h0C;
  localparam logic [7:0] A_DTAG1 = 8'h10;
  localparam logic [7:0] A_DTAG2 = 8'h14;
  localparam logic [7:0] A_DSCPL = 8'h18;
  localparam logic [7:0] A_DSCPH = 8'h1C;
  localparam logic [7:0] A_STAT = 8'h20;
  // Table windows, selected by the upper address bits.
  localparam logic [1:0] A_VLAN_SEL = 2'h1;
  localparam logic [2:0] A_STATIC_SEL = 3'h4;
  localparam logic [1:0] A_DYN_SEL = 2'h3;
  // Control fields.
  localparam int CTRL_VLAN = 0;
  localparam int CTRL_WFQ = 1;
  // Port configuration fields, three bits each, bit n is port n+1; insert source is nine bits, bit 3*egress+source.
  localparam int PC_SPLIT = 0;
  localparam int PC_HIPRI = 3;
  localparam int PC_CEIL = 6;
  localparam int PC_INS = 9;
  localparam int PC_STRIP = 12;
  localparam int PC_INSSRC = 15;
  // VLAN entry fields.
  localparam int VT_VID = 0;
  localparam int VT_FID = 12;
  localparam int VT_MEM = 16;
  localparam int VT_VAL = 19;
  // Static entry upper word fields.
  localparam int ST_PORT = 16;
  localparam int ST_USE = 19;
  localparam int ST_FID = 20;
  localparam int ST_VAL = 24;
  // Dynamic entry upper word fields.
  localparam int DY_FID = 16;
  localparam int DY_PORT = 20;
  localparam int DY_VAL = 22;
  // Table depths.
  localparam int NVLAN = 16;
  localparam int NST = 4;
  localparam int NDYN = 8;
  localparam logic [31:0] REG_RST = 32'h0000_0000;
  localparam logic [15:0] TAG_RST = 16'h0000;
endpackage

// ==== hw/switch_fwd_qos.sv ====
/*
  Forwarding, learning, classification, tag editing and egress queue
  selection of a three-port switch. Ports 1..3 are coded 0..2.
  Assumes one header descriptor per frame from the parser and a register
  master on the same clock; the sleep input is asynchronous.
*/
// The strobed register port and the register offsets were left to the implementer.
// Function
// - Processor sleep enables bypass between ports 1, 2.
// - Bypass drops port-3 frames, no buffer used.
// - Sixteen-entry table maps VLAN id to index.
// - Untagged or null-id frames use port default.
// - Invalid VLAN id drops frame, no learning.
// - Learn on index+source, lookup index+destination.
// - Double miss floods to VLAN member ports.
// - Dynamic hit forwards to its single port.
// - Static hit without index flag uses ports.
// - Flagged static hit needs index match, else fallback.
// - Four egress queues, queue 3 highest.
// - Unsplit queue treats all priorities alike.
// - Strict or weighted fair queue scheduling selectable.
// - High-priority ingress port marks frames high.
// - Tag priority mapped through programmable table.
// - Per egress insert or strip VLAN tag.
// - Insert source default tag per allowed source.
// - Tag change forces frame check recompute.
// - Ceiling caps priority at port default priority.
// - Six ToS bits index the DSCP register bits.
`timescale 1ns/10ps
module switch_fwd_qos
  import switch_fwd_pkg::*;
(
  // Clock, reset and clock enable.
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  // Register port.
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // Processor power state.
  input wire logic cpu_sleep_i,
  output logic bypass_o,
  // Frame header descriptor.
  input wire logic hdr_valid_i,
  input wire logic [1:0] hdr_src_i,
  input wire logic [47:0] hdr_da_i,
  input wire logic [47:0] hdr_sa_i,
  input wire logic hdr_tagged_i,
  input wire logic [15:0] hdr_tci_i,
  input wire logic hdr_ip_i,
  input wire logic [7:0] hdr_tos_i,
  // Forwarding decision.
  output logic fwd_valid_o,
  output logic fwd_drop_o,
  output logic fwd_buf_o,
  output logic [2:0] fwd_ports_o,
  output logic [5:0] fwd_queue_o,
  output logic [2:0] fwd_ins_o,
  output logic [2:0] fwd_strip_o,
  output logic [2:0] fwd_crc_o,
  output logic [15:0] fwd_tci_o,
  output logic fwd_learn_o,
  // Egress scheduler.
  input wire logic [2:0] tx_pick_i,
  input wire logic [11:0] tx_ne_i,
  output logic [2:0] tx_grant_o,
  output logic [5:0] tx_queue_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (reset_i);

  // One-hot port set from a port code.
  function automatic logic [2:0] port_oh(input logic [1:0] code);
    port_oh = 3'b001 << code;
  endfunction

  // Highest non-empty queue of four.
  function automatic logic [1:0] top_q(input logic [3:0] ne);
    top_q = ne[3] ? 2'd3 : ne[2] ? 2'd2 : ne[1] ? 2'd1 : 2'd0;
  endfunction

  logic [31:0] ctrl_reg, pcfg_reg, rd_next;
  logic [15:0] pmap_reg, dtag;
  logic [15:0] dtag_reg [3];
  logic [63:0] dscp_reg;
  logic [31:0] vt_reg [NVLAN];
  logic [31:0] stl_reg [NST], sth_reg [NST];
  logic [47:0] dy_mac_reg [NDYN];
  logic [3:0] dy_fid_reg [NDYN];
  logic [1:0] dy_port_reg [NDYN];
  logic [NDYN-1:0] dy_val_reg;
  logic [2:0] dy_ptr_reg;
  logic sleep_s1_reg;
  logic [2:0] split, src_oh, members, sports, lidx, ports, pri;
  logic [1:0] src, dport, cls;
  logic [11:0] vid;
  logic [3:0] filter_index, sfid;
  logic vhit, shit, suse, dhit, lhit, drop;

  assign split = pcfg_reg[PC_SPLIT +: 3];

  // Two-stage synchroniser; the synced level is the bypass state.
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sleep_s1_reg <= 1'b0;
      bypass_o <= 1'b0;
    end else if (ce_i) begin
      sleep_s1_reg <= cpu_sleep_i;
      bypass_o <= sleep_s1_reg;
    end
  end

  // Software writes to configuration and table registers.
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ctrl_reg <= REG_RST;
      pcfg_reg <= REG_RST;
      pmap_reg <= TAG_RST;
      dscp_reg <= {REG_RST, REG_RST};
      for (int i = 0; i < 3; i++) begin
        dtag_reg[i] <= TAG_RST;
      end
      for (int i = 0; i < NVLAN; i++) begin
        vt_reg[i] <= REG_RST;
      end
      for (int i = 0; i < NST; i++) begin
        stl_reg[i] <= REG_RST;
        sth_reg[i] <= REG_RST;
      end
    end else if (ce_i && reg_wr_i) begin
      case (reg_addr_i)
        A_CTRL: ctrl_reg <= {30'h0000_0000, reg_wdata_i[1:0]};
        A_PCFG: pcfg_reg <= {8'h00, reg_wdata_i[23:0]};
        A_PMAP: pmap_reg <= reg_wdata_i[15:0];
        A_DTAG0: dtag_reg[0] <= reg_wdata_i[15:0];
        A_DTAG1: dtag_reg[1] <= reg_wdata_i[15:0];
        A_DTAG2: dtag_reg[2] <= reg_wdata_i[15:0];
        A_DSCPL: dscp_reg[31:0] <= reg_wdata_i;
        A_DSCPH: dscp_reg[63:32] <= reg_wdata_i;
        default: begin
          if (reg_addr_i[7:6] == A_VLAN_SEL) begin
            vt_reg[reg_addr_i[5:2]] <= {12'h000, reg_wdata_i[19:0]};
          end else if (reg_addr_i[7:5] == A_STATIC_SEL) begin
            if (reg_addr_i[2]) begin
              sth_reg[reg_addr_i[4:3]] <= {7'h00, reg_wdata_i[24:0]};
            end else begin
              stl_reg[reg_addr_i[4:3]] <= reg_wdata_i;
            end
          end
        end
      endcase
    end
  end

  // Read decode; unmapped addresses read zero.
  always_comb begin
    rd_next = REG_RST;
    case (reg_addr_i)
      A_CTRL: rd_next = ctrl_reg;
      A_PCFG: rd_next = pcfg_reg;
      A_PMAP: rd_next = {16'h0000, pmap_reg};
      A_DTAG0: rd_next = {16'h0000, dtag_reg[0]};
      A_DTAG1: rd_next = {16'h0000, dtag_reg[1]};
      A_DTAG2: rd_next = {16'h0000, dtag_reg[2]};
      A_DSCPL: rd_next = dscp_reg[31:0];
      A_DSCPH: rd_next = dscp_reg[63:32];
      A_STAT: rd_next = {29'h0000_0000, dy_ptr_reg[1:0] == 2'd0 && dy_ptr_reg[2], 1'b0, bypass_o};
      default: begin
        if (reg_addr_i[7:6] == A_VLAN_SEL) begin
          rd_next = vt_reg[reg_addr_i[5:2]];
        end else if (reg_addr_i[7:5] == A_STATIC_SEL) begin
          rd_next = reg_addr_i[2] ? sth_reg[reg_addr_i[4:3]] : stl_reg[reg_addr_i[4:3]];
        end else if (reg_addr_i[7:6] == A_DYN_SEL) begin
          rd_next = reg_addr_i[2] ?
            {9'h000, dy_val_reg[reg_addr_i[5:3]], dy_port_reg[reg_addr_i[5:3]],
             dy_fid_reg[reg_addr_i[5:3]], dy_mac_reg[reg_addr_i[5:3]][47:32]} :
            dy_mac_reg[reg_addr_i[5:3]][31:0];
        end
      end
    endcase
  end

  // Read data stand for the one cycle after the read strobe.
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      reg_rdata_o <= REG_RST;
    end else if (ce_i) begin
      reg_rdata_o <= reg_rd_i ? rd_next : REG_RST;
    end
  end

  // Lookup and classification of the current header.
  always_comb begin
    src = (hdr_src_i == 2'd3) ? 2'd2 : hdr_src_i;
    src_oh = port_oh(src);
    dtag = dtag_reg[src];
    // A null id in a tag means the default id is used.
    vid = (hdr_tagged_i && hdr_tci_i[11:0] != 12'h000) ? hdr_tci_i[11:0] : dtag[11:0];
    vhit = 1'b0;
    filter_index = 4'h0;
    members = 3'b111;
    for (int i = 0; i < NVLAN; i++) begin
      if (vt_reg[i][VT_VAL] && vt_reg[i][VT_VID +: 12] == vid && !vhit) begin
        vhit = 1'b1;
        filter_index = vt_reg[i][VT_FID +: 4];
        members = vt_reg[i][VT_MEM +: 3];
      end
    end
    if (!ctrl_reg[CTRL_VLAN]) begin
      vhit = 1'b1;
      filter_index = 4'h0;
      members = 3'b111;
    end
    shit = 1'b0;
    sports = 3'b000;
    suse = 1'b0;
    sfid = 4'h0;
    for (int i = 0; i < NST; i++) begin
      if (sth_reg[i][ST_VAL] && {sth_reg[i][15:0], stl_reg[i]} == hdr_da_i && !shit) begin
        shit = 1'b1;
        sports = sth_reg[i][ST_PORT +: 3];
        suse = sth_reg[i][ST_USE];
        sfid = sth_reg[i][ST_FID +: 4];
      end
    end
    dhit = 1'b0;
    dport = 2'd0;
    lhit = 1'b0;
    lidx = 3'd0;
    for (int i = 0; i < NDYN; i++) begin
      if (dy_val_reg[i] && dy_fid_reg[i] == filter_index && dy_mac_reg[i] == hdr_da_i && !dhit) begin
        dhit = 1'b1;
        dport = dy_port_reg[i];
      end
      if (dy_val_reg[i] && dy_fid_reg[i] == filter_index && dy_mac_reg[i] == hdr_sa_i && !lhit) begin
        lhit = 1'b1;
        lidx = 3'(i);
      end
    end
    if (shit && (!suse || sfid == filter_index)) begin
      ports = sports;
    end else if (dhit) begin
      ports = port_oh(dport);
    end else begin
      ports = members;
    end
    ports = ports & ~src_oh;
    if (bypass_o) begin
      ports[2] = 1'b0;
    end
    drop = !vhit || ports == 3'b000;
    pri = hdr_tagged_i ? hdr_tci_i[15:13] : dtag[15:13];
    if (pcfg_reg[PC_CEIL + 32'(src)] && pri > dtag[15:13]) begin
      pri = dtag[15:13];
    end
    if (pcfg_reg[PC_HIPRI + 32'(src)]) begin
      cls = 2'd3;
    end else if (hdr_tagged_i) begin
      cls = pmap_reg[{pri, 1'b0} +: 2];
    end else if (hdr_ip_i) begin
      cls = dscp_reg[hdr_tos_i[7:2]] ? 2'd3 : 2'd0;
    end else begin
      cls = 2'd0;
    end
  end

  // Registered decision, one cycle after the header.
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      fwd_valid_o <= 1'b0;
      fwd_drop_o <= 1'b0;
      fwd_buf_o <= 1'b0;
      fwd_ports_o <= 3'b000;
      fwd_tci_o <= TAG_RST;
      fwd_learn_o <= 1'b0;
    end else if (ce_i) begin
      fwd_valid_o <= hdr_valid_i;
      if (hdr_valid_i) begin
        fwd_drop_o <= drop;
        fwd_buf_o <= !drop;
        fwd_ports_o <= drop ? 3'b000 : ports;
        fwd_tci_o <= {pri, hdr_tagged_i ? hdr_tci_i[12] : dtag[12], vid};
        fwd_learn_o <= vhit;
      end
    end
  end

  // Per egress tag editing and queue choice.
  generate
    for (genvar e = 0; e < 3; e++) begin : g_egr
      always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
          fwd_ins_o[e] <= 1'b0;
          fwd_strip_o[e] <= 1'b0;
          fwd_crc_o[e] <= 1'b0;
          fwd_queue_o[2*e +: 2] <= 2'd0;
        end else if (ce_i && hdr_valid_i) begin
          fwd_ins_o[e] <= pcfg_reg[PC_INS + e] && !hdr_tagged_i
                          && pcfg_reg[PC_INSSRC + 3*e + 32'(src)];
          fwd_strip_o[e] <= pcfg_reg[PC_STRIP + e] && hdr_tagged_i;
          fwd_crc_o[e] <= (pcfg_reg[PC_INS + e] && !hdr_tagged_i && pcfg_reg[PC_INSSRC + 3*e + 32'(src)])
                          || (pcfg_reg[PC_STRIP + e] && hdr_tagged_i);
          fwd_queue_o[2*e +: 2] <= split[e] ? cls : 2'd0;
        end
      end
    end
  endgenerate

  // Address learning into the dynamic table with round-robin replacement.
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      dy_val_reg <= '0;
      dy_ptr_reg <= 3'd0;
      for (int i = 0; i < NDYN; i++) begin
        dy_mac_reg[i] <= 48'h0000_0000_0000;
        dy_fid_reg[i] <= 4'h0;
        dy_port_reg[i] <= 2'd0;
      end
    end else if (ce_i && hdr_valid_i && vhit) begin
      if (lhit) begin
        dy_port_reg[lidx] <= src;
      end else begin
        dy_mac_reg[dy_ptr_reg] <= hdr_sa_i;
        dy_fid_reg[dy_ptr_reg] <= filter_index;
        dy_port_reg[dy_ptr_reg] <= src;
        dy_val_reg[dy_ptr_reg] <= 1'b1;
        dy_ptr_reg <= dy_ptr_reg + 3'd1;
      end
    end
  end

  // Egress schedulers, strict or weighted 8:4:2:1 by slot counter.
  generate
    for (genvar p = 0; p < 3; p++) begin : g_sch
      logic [3:0] slot_reg, ne;
      logic [1:0] want;
      assign ne = tx_ne_i[4*p +: 4];
      assign want = slot_reg[0] ? 2'd3 : slot_reg[1] ? 2'd2 : slot_reg[2] ? 2'd1 : 2'd0;
      always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
          slot_reg <= 4'h1;
          tx_grant_o[p] <= 1'b0;
          tx_queue_o[2*p +: 2] <= 2'd0;
        end else if (ce_i) begin
          tx_grant_o[p] <= tx_pick_i[p] && ne != 4'h0;
          if (tx_pick_i[p]) begin
            if (!split[p]) begin
              tx_queue_o[2*p +: 2] <= 2'd0;
            end else if (ctrl_reg[CTRL_WFQ] && ne[want]) begin
              tx_queue_o[2*p +: 2] <= want;
            end else begin
              tx_queue_o[2*p +: 2] <= top_q(ne);
            end
            slot_reg <= (slot_reg == 4'hF) ? 4'h1 : slot_reg + 4'h1;
          end
        end
      end
      AST_UNSPLIT_Q0: assert property ($past(ce_i && tx_pick_i[p] && !split[p]) |-> tx_queue_o[2*p +: 2] == 2'd0)
        else $error("unsplit egress picked nonzero queue");
      AST_STRICT_TOP: assert property ($past(ce_i && tx_pick_i[p] && split[p] && !ctrl_reg[CTRL_WFQ] && ne[3])
        |-> tx_queue_o[2*p +: 2] == 2'd3)
        else $error("strict scheduler skipped queue 3");
    end
  endgenerate

  sequence sleep_held;
    (cpu_sleep_i && ce_i) [*2];
  endsequence
  AST_BYPASS_ENTER: assert property (sleep_held |=> bypass_o)
    else $error("bypass not entered after sleep");
  AST_BYPASS_NO_P3: assert property ($past(ce_i && bypass_o) && fwd_valid_o |-> !fwd_ports_o[2])
    else $error("port 3 forwarded in bypass");
  AST_DROP_NO_BUF: assert property (fwd_valid_o && fwd_drop_o |-> !fwd_buf_o && fwd_ports_o == 3'b000)
    else $error("dropped frame holds buffer");
  AST_NO_LEARN_BAD_VID: assert property (ce_i && hdr_valid_i && !vhit |=> fwd_drop_o && !fwd_learn_o)
    else $error("invalid VLAN id not dropped");
  AST_CRC_ON_EDIT: assert property (fwd_valid_o |-> fwd_crc_o == (fwd_ins_o | fwd_strip_o))
    else $error("tag edit without check recompute");
  AST_CEILING: assert property (ce_i && hdr_valid_i && pcfg_reg[PC_CEIL + 32'(src)]
    |=> fwd_tci_o[15:13] <= $past(dtag[15:13]))
    else $error("priority above ceiling");
  AST_HIPRI_PORT: assert property (ce_i && hdr_valid_i && pcfg_reg[PC_HIPRI + 32'(src)] && split == 3'b111
    |=> fwd_queue_o == 6'h3F)
    else $error("high priority port not queued high");
  AST_STATIC_PLAIN: assert property (ce_i && hdr_valid_i && vhit && shit && !suse && !bypass_o
    |=> fwd_ports_o == $past(sports & ~src_oh))
    else $error("static ports not used");
endmodule

// ==== verif/egress_model.sv ====
/*
  Egress queue model for the scheduler ports: it holds the non-empty
  flags of the twelve transmit queues and issues pick requests.
  Assumes the bench loads the flags and requests picks on the same clock.
*/
`timescale 1ns/10ps
module egress_model (
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic reset_i,
  // Bench control.
  input wire logic [2:0] req_i,
  input wire logic load_i,
  input wire logic [11:0] fill_i,
  // Scheduler answer.
  input wire logic [2:0] tx_grant_i,
  input wire logic [5:0] tx_queue_i,
  // Scheduler request.
  output logic [2:0] tx_pick_o,
  output logic [11:0] tx_ne_o
);
  // A granted queue sends one frame and is then taken as empty.
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      tx_pick_o <= 3'h0;
      tx_ne_o <= 12'h000;
    end else begin
      tx_pick_o <= req_i;
      if (load_i) begin
        tx_ne_o <= fill_i;
      end else begin
        for (int p = 0; p < 3; p++) begin
          if (tx_grant_i[p]) begin
            tx_ne_o[4*p+tx_queue_i[2*p+:2]] <= 1'h0;
          end
        end
      end
    end
  end
endmodule

// ==== verif/switch_vlan_forwarding_qos_test.sv ====
/*
  Self-checking bench of the switch forwarding and QoS block.
  Assumes the egress queue model drives the scheduler inputs.
*/
`timescale 1ns/10ps
module switch_vlan_forwarding_qos_test;
  import switch_fwd_pkg::*;
  logic core_clk_i = 1'h0, reset_i = 1'h1, ce_i = 1'h1;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0000_0000, reg_rdata_o, pcfg, pmap;
  logic reg_wr_i = 1'h0, reg_rd_i = 1'h0, cpu_sleep_i = 1'h0, bypass_o;
  logic hdr_valid_i = 1'h0, hdr_tagged_i = 1'h0, hdr_ip_i = 1'h0, tg, ip, load = 1'h0;
  logic [1:0] hdr_src_i = 2'h0, s, c;
  logic [47:0] hdr_da_i = 48'h0, hdr_sa_i = 48'h0;
  logic [15:0] hdr_tci_i = 16'h0000, tci, tci_seen, dtag [3];
  logic [7:0] hdr_tos_i = 8'h00, tos;
  logic fwd_valid_o, fwd_drop_o, fwd_buf_o, fwd_learn_o;
  logic [2:0] fwd_ports_o, fwd_ins_o, fwd_strip_o, fwd_crc_o, tx_pick_i, tx_grant_o, req = 3'h0, ep, ix, sx;
  logic [5:0] fwd_queue_o, tx_queue_o, qm, qx;
  logic [11:0] tx_ne_i, fill = 12'h000, m;
  logic [63:0] dscp;
  int fails = 0, n_compared = 0, cyc = 0;
  localparam logic [47:0] MA = 48'h0400_0000_0001, NA = 48'h0400_0000_0002, SZ = 48'h0400_0000_0003;
  localparam logic [47:0] SS = 48'h0600_0000_0001, TS = 48'h0600_0000_0002, UK = 48'h0200_0000_0001;

  switch_fwd_qos dut_u (.core_clk_i, .reset_i, .ce_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .cpu_sleep_i, .bypass_o, .hdr_valid_i, .hdr_src_i, .hdr_da_i, .hdr_sa_i, .hdr_tagged_i,
    .hdr_tci_i, .hdr_ip_i, .hdr_tos_i, .fwd_valid_o, .fwd_drop_o, .fwd_buf_o, .fwd_ports_o, .fwd_queue_o,
    .fwd_ins_o, .fwd_strip_o, .fwd_crc_o, .fwd_tci_o(tci_seen), .fwd_learn_o, .tx_pick_i, .tx_ne_i, .tx_grant_o,
    .tx_queue_o);
  egress_model eq_u (.core_clk_i, .reset_i, .req_i(req), .load_i(load), .fill_i(fill),
    .tx_grant_i(tx_grant_o), .tx_queue_i(tx_queue_o), .tx_pick_o(tx_pick_i), .tx_ne_o(tx_ne_i));
  // Clock and hang guard.
  always #4 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      final_report();
    end
  end

  task automatic final_report();
    if (fails == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input string nm, input logic [47:0] seen, input logic [47:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= v;
    reg_wr_i <= 1'h1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'h0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'h1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'h0;
    #1;
    check("rdata", reg_rdata_o, exp);
  endtask

  task automatic hdr(input logic [1:0] hs, input logic [47:0] da, input logic [47:0] sa, input logic htg,
                     input logic [15:0] htci, input logic hip, input logic [7:0] htos);
    @(posedge core_clk_i);
    hdr_valid_i <= 1'h1;
    hdr_src_i <= hs;
    hdr_da_i <= da;
    hdr_sa_i <= sa;
    hdr_tagged_i <= htg;
    hdr_tci_i <= htci;
    hdr_ip_i <= hip;
    hdr_tos_i <= htos;
    @(posedge core_clk_i);
    hdr_valid_i <= 1'h0;
    #1;
    check("fwd_valid", fwd_valid_o, 1'h1);
  endtask

  task automatic ld(input logic [11:0] v);
    @(posedge core_clk_i);
    load <= 1'h1;
    fill <= v;
    @(posedge core_clk_i);
    load <= 1'h0;
    m = v;
  endtask

  task automatic pk(input int p, input logic g, input logic [1:0] q);
    @(posedge core_clk_i);
    req <= 3'(1 << p);
    @(posedge core_clk_i);
    req <= 3'h0;
    @(posedge core_clk_i);
    #1;
    check("grant", tx_grant_o[p], g);
    if (g) check("queue", tx_queue_o[2*p+:2], q);
  endtask

  // Priority after the ingress ceiling.
  function automatic logic [2:0] cap_pri(input logic [1:0] fs, input logic [2:0] p);
    return (pcfg[6+fs] && p > dtag[fs][15:13]) ? dtag[fs][15:13] : p;
  endfunction

  // Final class: port priority, then tag priority, then code point.
  function automatic logic [1:0] cls(input logic [1:0] fs, input logic ft, input logic [2:0] p,
                                     input logic fi, input logic [7:0] ft_tos);
    if (pcfg[3+fs]) return 2'h3;
    if (ft) return pmap[2*cap_pri(fs, p)+:2];
    if (fi) return dscp[ft_tos[7:2]] ? 2'h3 : 2'h0;
    return 2'h0;
  endfunction

  function automatic logic [1:0] top(input logic [3:0] v);
    top = 2'h0;
    for (int i = 0; i < 4; i++) if (v[i]) top = 2'(i);
  endfunction

  initial begin
    void'($urandom(55));
    repeat (12) @(posedge core_clk_i);
    reset_i <= 1'h0;
    hdr(2'h1, UK, MA, 1'h0, 16'h0000, 1'h0, 8'h00);
    check("ports", fwd_ports_o, 3'h5);
    hdr(2'h0, MA, SZ, 1'h0, 16'h0000, 1'h0, 8'h00);
    check("ports", fwd_ports_o, 3'h2);
    wr(8'h40, 32'h000F_3005);
    wr(8'h44, 32'h000B_4006);
    wr(A_DTAG0, 32'h0000_0005);
    wr(8'h80, 32'h0000_0001);
    wr(8'h84, 32'h0104_0600);
    wr(8'h88, 32'h0000_0002);
    wr(8'h8C, 32'h013C_0600);
    wr(A_CTRL, 32'h0000_0001);
    hdr(2'h2, UK, NA, 1'h1, 16'h0005, 1'h0, 8'h00);
    check("learn", fwd_learn_o, 1'h1);
    check("ports", fwd_ports_o, 3'h3);
    hdr(2'h0, NA, SZ, 1'h1, 16'h0005, 1'h0, 8'h00);
    check("ports", fwd_ports_o, 3'h4);
    hdr(2'h0, NA, SZ, 1'h1, 16'h0006, 1'h0, 8'h00);
    check("ports", fwd_ports_o, 3'h2);
    hdr(2'h0, NA, SZ, 1'h1, 16'h0009, 1'h0, 8'h00);
    check("drop", {fwd_drop_o, fwd_buf_o, fwd_learn_o}, 3'h4);
    hdr(2'h0, NA, SZ, 1'h0, 16'h0000, 1'h0, 8'h00);
    check("ports", fwd_ports_o, 3'h4);
    hdr(2'h0, NA, SZ, 1'h1, 16'hE000, 1'h0, 8'h00);
    check("ports", fwd_ports_o, 3'h4);
    check("vid", tci_seen[11:0], 12'h005);
    hdr(2'h0, SS, SZ, 1'h1, 16'h0006, 1'h0, 8'h00);
    check("ports", fwd_ports_o, 3'h4);
    hdr(2'h0, TS, SZ, 1'h1, 16'h0005, 1'h0, 8'h00);
    check("ports", fwd_ports_o, 3'h4);
    hdr(2'h0, TS, SZ, 1'h1, 16'h0006, 1'h0, 8'h00);
    check("ports", fwd_ports_o, 3'h2);
    // Entry 2 holds the address learned from port 3 under index 3.
    rdc(8'hD0, 32'h0000_0002);
    rdc(8'hD4, 32'h0063_0400);
    @(posedge core_clk_i) cpu_sleep_i <= 1'h1;
    repeat (4) @(posedge core_clk_i);
    check("bypass", bypass_o, 1'h1);
    rdc(A_STAT, 32'h0000_0001);
    hdr(2'h0, SS, SZ, 1'h1, 16'h0006, 1'h0, 8'h00);
    check("drop", {fwd_drop_o, fwd_buf_o, fwd_ports_o}, 5'h10);
    hdr(2'h0, UK, SZ, 1'h1, 16'h0005, 1'h0, 8'h00);
    check("ports", fwd_ports_o, 3'h2);
    // Second reset, then reset values and an unmapped place.
    @(posedge core_clk_i);
    cpu_sleep_i <= 1'h0;
    reset_i <= 1'h1;
    repeat (3) @(posedge core_clk_i);
    reset_i <= 1'h0;
    for (int i = 0; i < 8; i++) rdc(8'(4 * i), (i >= 3 && i <= 5) ? {16'h0000, TAG_RST} : REG_RST);
    wr(8'h30, 32'hFFFF_FFFF);
    rdc(8'h30, 32'h0000_0000);
    // A write while the clock enable is low must not land.
    @(posedge core_clk_i) ce_i <= 1'h0;
    wr(A_PMAP, 32'h0000_FFFF);
    ce_i <= 1'h1;
    rdc(A_PMAP, 32'h0000_0000);
    wr(A_CTRL, 32'h0000_0002);
    wr(A_PCFG, 32'h0000_0007);
    for (int k = 1; k < 5; k++) begin
      ld(12'h00F);
      pk(0, 1'h1, k[0] ? 2'h3 : k[1] ? 2'h2 : 2'h1);
    end
    wr(A_CTRL, 32'h0000_0000);
    for (int r = 0; r < 3; r++) begin
      pcfg = $urandom & 32'h00FF_FFFF;
      pmap = $urandom & 32'h0000_FFFF;
      dscp = {$urandom, $urandom};
      for (int i = 0; i < 3; i++) dtag[i] = 16'($urandom);
      wr(A_PCFG, pcfg);
      wr(A_PMAP, pmap);
      wr(A_DSCPL, dscp[31:0]);
      wr(A_DSCPH, dscp[63:32]);
      for (int i = 0; i < 3; i++) wr(8'(A_DTAG0 + 4 * i), {16'h0000, dtag[i]});
      for (int n = 0; n < 12; n++) begin
        s = 2'($urandom_range(2, 0));
        tg = 1'($urandom);
        ip = 1'($urandom);
        tci = n < 2 ? {3'($urandom), 13'h0000} : 16'($urandom);
        tos = 8'($urandom);
        hdr(s, {8'h02, 40'($urandom)}, {8'h04, 40'($urandom)}, tg, tci, ip, tos);
        ep = 3'h7 & ~(3'h1 << s);
        c = cls(s, tg, tci[15:13], ip, tos);
        for (int e = 0; e < 3; e++) begin
          qm[2*e+:2] = {2{ep[e]}};
          qx[2*e+:2] = pcfg[e] ? c : 2'h0;
          ix[e] = pcfg[9+e] & ~tg & pcfg[15+3*e+s];
          sx[e] = pcfg[12+e] & tg;
        end
        check("ports", fwd_ports_o, ep);
        check("queue", fwd_queue_o & qm, qx & qm);
        check("ins", fwd_ins_o & ep, ix & ep);
        check("strip", fwd_strip_o & ep, sx & ep);
        check("crc", fwd_crc_o & ep, (ix | sx) & ep);
        check("tci", tci_seen, tg ? {cap_pri(s, tci[15:13]), tci[12],
          tci[11:0] == 12'h000 ? dtag[s][11:0] : tci[11:0]} : dtag[s]);
      end
    end
    wr(A_PCFG, 32'h0000_0006);
    ld(12'($urandom));
    for (int p = 0; p < 3; p++) begin
      for (int k = 0; k < 5; k++) begin
        c = p == 0 ? 2'h0 : top(m[4*p+:4]);
        pk(p, |m[4*p+:4], c);
        m[4*p+c] = 1'h0;
      end
    end
    final_report();
  end
endmodule
